// *** common/shra_pkg.sv ***
// constants shared by the hidden-clock access controller and its cycle engine
// assumes a 200 MHz aclk and an asynchronous byte-wide memory part on the pins
`default_nettype none

package shra_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 21; // byte address pins
	localparam int DATA_W = 8; // data pins
	localparam int SCRATCH_W = 19; // scratch address stays in lowest 512kB
	localparam int XFER_BITS = 64; // unlock and transfer length in cycles
	localparam int BIT_W = 6; // index into a 64-bit stream
	localparam int CNT_W = 8; // phase counter width
	localparam int AXI_ADDR_W = 8; // register window

	// ----------------------------------------------------------------
	// unlock pattern, bytes c5 3a a3 5c twice, bit 0 sent first
	// ----------------------------------------------------------------
	localparam logic [63:0] UNLOCK_PATTERN = 64'h5CA3_3AC5_5CA3_3AC5;

	// ----------------------------------------------------------------
	// timing, figures in ns and derived cycle counts
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int ADDR_SETUP_NS = 10; // address stable before strobes
	localparam int ADDRESS_TO_DATA_NS = 100; // address_to_data_time
	localparam int WRITE_PULSE_NS = 75; // strobe low time on a write
	localparam int WRITE_RECOVERY_NS = 10; // write_recovery_time
	localparam int SYNC_STAGES = 2; // pin synchroniser depth
	localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (ADDRESS_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = ACCESS_CYC + SYNC_STAGES + 1;
	localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_SCRATCH = 8'h14;
	localparam logic [7:0] REG_TIME_LO = 8'h18;
	localparam logic [7:0] REG_TIME_HI = 8'h1C;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam logic [SCRATCH_W-1:0] RST_SCRATCH = 19'h00000;
	localparam logic [ADDR_W-1:0] RST_ADDR = 21'h000000;
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [63:0] RST_TIME = 64'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// commands written to the control register, bits 1:0
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SHRA_CMD_MEM_WR,
		SHRA_CMD_MEM_RD,
		SHRA_CMD_CLK_RD,
		SHRA_CMD_CLK_WR
	} shra_cmd_e;

endpackage

`default_nettype wire

// *** core/shra_cycle.sv ***
// one asynchronous memory cycle on the device pins, read or write
// assumes start only while idle; data_in comes from the pins, unsynchronised
`timescale 1ns/10ps
`default_nettype none

module shra_cycle (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request from the sequencer
	input wire logic start,
	input wire logic is_write,
	input wire logic [shra_pkg::ADDR_W-1:0] addr,
	input wire logic [shra_pkg::DATA_W-1:0] wdata,
	output logic done,
	output logic [shra_pkg::DATA_W-1:0] rdata,
	// device pins
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_drive_n,
	output logic [shra_pkg::ADDR_W-1:0] byte_address,
	output logic [shra_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [shra_pkg::DATA_W-1:0] data_in
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOV} shra_cy_e;
	shra_cy_e state_q; // cycle phase
	logic wr_q; // held direction
	logic [shra_pkg::CNT_W-1:0] cnt_q; // phase cycles left
	logic [shra_pkg::DATA_W-1:0] sync1_q; // first pin stage, read only by sync2_q
	logic [shra_pkg::DATA_W-1:0] sync2_q; // second pin stage

	// phase lengths at counter width
	wire logic [shra_pkg::CNT_W-1:0] setup_len = shra_pkg::CNT_W'(shra_pkg::SETUP_CYC - 1);
	wire logic [shra_pkg::CNT_W-1:0] read_len = shra_pkg::CNT_W'(shra_pkg::READ_CYC - 1);
	wire logic [shra_pkg::CNT_W-1:0] write_len = shra_pkg::CNT_W'(shra_pkg::WRITE_CYC - 1);
	wire logic [shra_pkg::CNT_W-1:0] recov_len = shra_pkg::CNT_W'(shra_pkg::RECOV_CYC - 1);
	wire logic cnt_end = (cnt_q == '0);

	// pin synchroniser, the strobe is long enough to cover its delay
	always_ff @(posedge aclk) begin
		sync1_q <= data_in;
		sync2_q <= sync1_q;
	end

	// phase sequencer; address held from setup through recovery
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= CY_IDLE;
			wr_q <= 1'b0;
			cnt_q <= '0;
			done <= 1'b0;
			rdata <= shra_pkg::RST_BYTE;
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_drive_n <= 1'b1;
			byte_address <= shra_pkg::RST_ADDR;
			data_out <= shra_pkg::RST_BYTE;
			data_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			cnt_q <= cnt_q - 1'b1;
			case (state_q)
				CY_IDLE: begin
					cnt_q <= setup_len;
					if (start) begin
						// address settles before any strobe falls
						state_q <= CY_SETUP;
						wr_q <= is_write;
						byte_address <= addr;
						data_out <= wdata;
						data_oe_n <= ~is_write;
					end
				end
				CY_SETUP: begin
					if (cnt_end) begin
						state_q <= CY_STROBE;
						cnt_q <= wr_q ? write_len : read_len;
						chip_select_n <= 1'b0;
						write_strobe_n <= ~wr_q;
						// output drive stays high on writes, no contention
						output_drive_n <= wr_q;
					end
				end
				CY_STROBE: begin
					if (cnt_end) begin
						// both strobes rise together, ending the cycle
						state_q <= CY_RECOV;
						cnt_q <= recov_len;
						chip_select_n <= 1'b1;
						write_strobe_n <= 1'b1;
						output_drive_n <= 1'b1;
						rdata <= sync2_q;
					end
				end
				CY_RECOV: begin
					// strobe high for the recovery time before the next cycle
					data_oe_n <= 1'b1;
					if (cnt_end) begin
						state_q <= CY_IDLE;
						done <= 1'b1;
					end
				end
				default: state_q <= CY_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** core/shra_ctrl.sv ***
// host controller that reaches memory and the hidden timekeeper of a byte-wide part
// assumes an axi4-lite master on aclk and the part wired straight to the pin ports
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module shra_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [shra_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [shra_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// device pins
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_drive_n,
	output logic [shra_pkg::ADDR_W-1:0] byte_address,
	output logic [shra_pkg::DATA_W-1:0] serial_lane_out,
	output logic serial_lane_oe_n,
	input wire logic [shra_pkg::DATA_W-1:0] serial_lane_in
);

	// ----------------------------------------------------------------
	// bus slave state
	// ----------------------------------------------------------------
	logic aw_full_q; // write address held
	logic w_full_q; // write data held
	logic [shra_pkg::AXI_ADDR_W-1:0] awaddr_q; // held write address
	logic [31:0] wdata_q; // held write data
	logic [3:0] wstrb_q; // held byte enables

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	shra_pkg::shra_cmd_e cmd_q; // last command accepted
	logic done_q, done_d; // sticky completion flag
	logic [shra_pkg::ADDR_W-1:0] addr_q; // memory cycle address
	logic [shra_pkg::DATA_W-1:0] wbyte_q; // memory write byte
	logic [shra_pkg::DATA_W-1:0] rbyte_q, rbyte_d; // memory read byte
	logic [shra_pkg::SCRATCH_W-1:0] scratch_q; // unlock scratch address
	logic [63:0] time_q, time_d; // clock image, sent or received

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {SQ_IDLE, SQ_MEM, SQ_PTR_RST, SQ_UNLOCK, SQ_XFER} shra_sq_e;
	shra_sq_e state_q, state_d; // sequence position
	logic [shra_pkg::BIT_W-1:0] bit_q, bit_d; // stream bit index
	logic start_q, start_d; // engine start pulse
	logic ewr_q, ewr_d; // engine direction
	logic [shra_pkg::ADDR_W-1:0] eaddr_q, eaddr_d; // engine address
	logic [shra_pkg::DATA_W-1:0] ebyte_q, ebyte_d; // engine write byte
	logic eng_done; // engine finished a cycle
	logic [shra_pkg::DATA_W-1:0] eng_rdata; // byte sampled by the engine

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	wire logic wr_fire = aw_full_q & w_full_q & ~bvalid; // both halves held
	wire logic idle = (state_q == SQ_IDLE);
	wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire logic w_ctrl = (awaddr_q == shra_pkg::REG_CTRL);
	wire logic w_status = (awaddr_q == shra_pkg::REG_STATUS);
	wire logic w_addr = (awaddr_q == shra_pkg::REG_ADDR);
	wire logic w_wbyte = (awaddr_q == shra_pkg::REG_WDATA);
	wire logic w_rbyte = (awaddr_q == shra_pkg::REG_RDATA);
	wire logic w_scratch = (awaddr_q == shra_pkg::REG_SCRATCH);
	wire logic w_tlo = (awaddr_q == shra_pkg::REG_TIME_LO);
	wire logic w_thi = (awaddr_q == shra_pkg::REG_TIME_HI);
	wire logic w_mapped = w_ctrl | w_status | w_addr | w_wbyte | w_rbyte | w_scratch | w_tlo | w_thi;
	// a command written while busy is dropped; software polls busy first
	wire logic go = wr_fire & w_ctrl & wstrb_q[0] & idle;
	wire logic done_clr = wr_fire & w_status & wstrb_q[0] & wdata_q[shra_pkg::STAT_DONE_BIT];
	wire logic [31:0] addr_m = ({11'h000, addr_q} & ~wmask) | (wdata_q & wmask);
	wire logic [31:0] scr_m = ({13'h0000, scratch_q} & ~wmask) | (wdata_q & wmask);
	wire logic [31:0] wb_m = ({24'h000000, wbyte_q} & ~wmask) | (wdata_q & wmask);
	wire logic [31:0] tlo_m = (time_q[31:0] & ~wmask) | (wdata_q & wmask);
	wire logic [31:0] thi_m = (time_q[63:32] & ~wmask) | (wdata_q & wmask);
	wire logic [shra_pkg::ADDR_W-1:0] scratch_addr = {2'h0, scratch_q};
	wire shra_pkg::shra_cmd_e new_cmd = shra_pkg::shra_cmd_e'(wdata_q[1:0]);
	wire logic clk_wr = (cmd_q == shra_pkg::SHRA_CMD_CLK_WR);
	wire logic last_bit = (bit_q == shra_pkg::BIT_W'(shra_pkg::XFER_BITS - 1));
	wire logic [shra_pkg::BIT_W-1:0] bit_nx = bit_q + 1'b1;

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	wire logic [31:0] status_word = {30'h0, done_q, ~idle};
	wire logic [31:0] rd_word =
		(araddr == shra_pkg::REG_CTRL) ? {30'h0, cmd_q} :
		(araddr == shra_pkg::REG_STATUS) ? status_word :
		(araddr == shra_pkg::REG_ADDR) ? {11'h000, addr_q} :
		(araddr == shra_pkg::REG_WDATA) ? {24'h000000, wbyte_q} :
		(araddr == shra_pkg::REG_RDATA) ? {24'h000000, rbyte_q} :
		(araddr == shra_pkg::REG_SCRATCH) ? {13'h0000, scratch_q} :
		(araddr == shra_pkg::REG_TIME_LO) ? time_q[31:0] :
		(araddr == shra_pkg::REG_TIME_HI) ? time_q[63:32] : 32'h0;
	wire logic r_mapped = (araddr[1:0] == 2'h0) && (araddr <= shra_pkg::REG_TIME_HI);

	// ----------------------------------------------------------------
	// write channels; address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= shra_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				awready <= 1'b0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_fire) begin
				// unmapped offsets answer slverr and change nothing
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= w_mapped ? shra_pkg::RESP_OKAY : shra_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// read channel, answer one cycle after the address is taken
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= shra_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= r_mapped ? shra_pkg::RESP_OKAY : shra_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers, frozen while a sequence runs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= shra_pkg::SHRA_CMD_MEM_WR;
			addr_q <= shra_pkg::RST_ADDR;
			wbyte_q <= shra_pkg::RST_BYTE;
			scratch_q <= shra_pkg::RST_SCRATCH;
		end else if (wr_fire && idle) begin
			if (go) cmd_q <= new_cmd;
			if (w_addr) addr_q <= addr_m[shra_pkg::ADDR_W-1:0];
			if (w_wbyte) wbyte_q <= wb_m[shra_pkg::DATA_W-1:0];
			// one fixed scratch word absorbs every unlock write
			if (w_scratch) scratch_q <= scr_m[shra_pkg::SCRATCH_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// sequencer: memory cycle, or pointer reset, unlock and transfer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		start_d = 1'b0;
		ewr_d = ewr_q;
		eaddr_d = eaddr_q;
		ebyte_d = ebyte_q;
		rbyte_d = rbyte_q;
		time_d = time_q;
		// set beats clear when both land in one cycle
		done_d = done_q & ~done_clr;
		// software loads the clock image only while idle
		if (wr_fire && idle && w_tlo) time_d[31:0] = tlo_m;
		if (wr_fire && idle && w_thi) time_d[63:32] = thi_m;
		case (state_q)
			SQ_IDLE: begin
				if (go) begin
					start_d = 1'b1;
					bit_d = '0;
					if (new_cmd == shra_pkg::SHRA_CMD_MEM_WR || new_cmd == shra_pkg::SHRA_CMD_MEM_RD) begin
						// plain access; without the pattern it reaches the array
						state_d = SQ_MEM;
						ewr_d = (new_cmd == shra_pkg::SHRA_CMD_MEM_WR);
						eaddr_d = addr_q;
						ebyte_d = wbyte_q;
					end else begin
						// a read first puts the comparison pointer at bit 0
						state_d = SQ_PTR_RST;
						ewr_d = 1'b0;
						eaddr_d = scratch_addr;
						ebyte_d = shra_pkg::RST_BYTE;
					end
				end
			end
			SQ_MEM: begin
				if (eng_done) begin
					state_d = SQ_IDLE;
					done_d = 1'b1;
					if (!ewr_q) rbyte_d = eng_rdata;
				end
			end
			SQ_PTR_RST: begin
				if (eng_done) begin
					// first pattern bit on lane 0, upper lanes zero
					state_d = SQ_UNLOCK;
					start_d = 1'b1;
					ewr_d = 1'b1;
					ebyte_d = {7'h00, shra_pkg::UNLOCK_PATTERN[0]};
				end
			end
			SQ_UNLOCK: begin
				// 64 back-to-back writes, no read may break the run
				if (eng_done) begin
					start_d = 1'b1;
					if (last_bit) begin
						// pattern complete; the stream now carries clock bits
						state_d = SQ_XFER;
						bit_d = '0;
						ewr_d = clk_wr;
						ebyte_d = {7'h00, time_q[0]};
					end else begin
						bit_d = bit_nx;
						ebyte_d = {7'h00, shra_pkg::UNLOCK_PATTERN[bit_nx]};
					end
				end
			end
			SQ_XFER: begin
				// always the full 64 bits, so every register moves whole
				if (eng_done) begin
					if (!ewr_q) time_d[bit_q] = eng_rdata[0];
					if (last_bit) begin
						state_d = SQ_IDLE;
						done_d = 1'b1;
					end else begin
						start_d = 1'b1;
						bit_d = bit_nx;
						ebyte_d = {7'h00, time_q[bit_nx]};
					end
				end
			end
			default: state_d = SQ_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= SQ_IDLE;
			bit_q <= '0;
			start_q <= 1'b0;
			ewr_q <= 1'b0;
			eaddr_q <= shra_pkg::RST_ADDR;
			ebyte_q <= shra_pkg::RST_BYTE;
			rbyte_q <= shra_pkg::RST_BYTE;
			time_q <= shra_pkg::RST_TIME;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			start_q <= start_d;
			ewr_q <= ewr_d;
			eaddr_q <= eaddr_d;
			ebyte_q <= ebyte_d;
			rbyte_q <= rbyte_d;
			time_q <= time_d;
			done_q <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// pin cycle engine; every pin leaves it from a flip-flop
	// ----------------------------------------------------------------
	shra_cycle u_cycle (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start_q),
		.is_write(ewr_q),
		.addr(eaddr_q),
		.wdata(ebyte_q),
		.done(eng_done),
		.rdata(eng_rdata),
		.chip_select_n(chip_select_n),
		.write_strobe_n(write_strobe_n),
		.output_drive_n(output_drive_n),
		.byte_address(byte_address),
		.data_out(serial_lane_out),
		.data_oe_n(serial_lane_oe_n),
		.data_in(serial_lane_in)
	);

endmodule

`default_nettype wire

// *** bench/shra_monitor.sv ***
// checker on the host controller's bus and pin ports
// assumes it is bound onto shra_ctrl and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module shra_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// device pins
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_drive_n,
	input wire logic serial_lane_oe_n,
	input wire logic [shra_pkg::ADDR_W-1:0] byte_address
);
	// ----------------------------------------------------------------
	// pin and bus checks, all on aclk
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_no_bus_fight: assert property (!write_strobe_n |-> output_drive_n)
		else $error("output drive low during a write");
	a_addr_held: assert property (!chip_select_n && !write_strobe_n |-> $stable(byte_address))
		else $error("address moved inside a write");
	a_addr_setup: assert property ($fell(chip_select_n) |-> byte_address == $past(byte_address, 2))
		else $error("address not settled before select");
	a_write_pulse: assert property ($fell(write_strobe_n) |->
		!write_strobe_n[*8] ##1 !write_strobe_n[*7] ##1 write_strobe_n)
		else $error("write strobe width wrong");
	a_recov_gap: assert property ($rose(write_strobe_n) |-> write_strobe_n[*2])
		else $error("write recovery too short");
	a_host_drives: assert property (!write_strobe_n |-> !serial_lane_oe_n)
		else $error("data lanes undriven during write");
	a_read_release: assert property (!output_drive_n |-> serial_lane_oe_n)
		else $error("host drives lanes during read");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_aw_block: assert property (bvalid |-> !awready)
		else $error("address taken with response pending");
endmodule

bind shra_ctrl shra_monitor shra_monitor_i (.*);

`default_nettype wire

// *** bench/shra_dev_model.sv ***
// behavioural byte-wide memory with the hidden timekeeper behind it
// assumes the host holds strobes steady for whole aclk periods
`timescale 1ns/10ps
`default_nettype none

module shra_dev_model (
	// sampling clock
	input wire logic aclk,
	// pins
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_drive_n,
	input wire logic [20:0] byte_address,
	input wire logic [7:0] lanes,
	output logic [7:0] dev_drv
);
	logic [7:0] mem [0:2097151]; // memory array
	logic [63:0] time_q = 64'h0; // timekeeper image
	logic [5:0] ptr_q = 6'h00; // compare or transfer pointer
	logic hunt_q = 1'b0; // unlock attempt alive
	logic xfer_q = 1'b0; // transfer phase
	logic wr_q = 1'b0; // cycle kind seen while selected
	logic cs_q = 1'b1; // select one sample ago
	logic [7:0] last_q = 8'h00; // last byte driven
	logic [7:0] rd_byte; // byte offered on a read
	logic [63:0] pat; // unlock pattern, lsb first

	assign pat = 64'h5CA3_3AC5_5CA3_3AC5;
	assign rd_byte = xfer_q ? {7'h00, time_q[ptr_q]} : mem[byte_address];
	// released lanes show the inverse of the last byte, never a stale copy
	// a falling write strobe takes the drivers off even with output drive low
	assign dev_drv = (!chip_select_n && !output_drive_n && write_strobe_n) ? rd_byte : ~last_q;

	// ----------------------------------------------------------------
	// cycle end: act when select rises
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		cs_q <= chip_select_n;
		if (!chip_select_n)
			wr_q <= !write_strobe_n;
		if (!chip_select_n && !output_drive_n)
			last_q <= rd_byte;
		if (chip_select_n && !cs_q) begin
			if (xfer_q) begin
				// memory untouched while bits move
				if (wr_q)
					time_q[ptr_q] <= lanes[0];
				ptr_q <= ptr_q + 6'h01;
				if (ptr_q == 6'h3F)
					xfer_q <= 1'b0;
			end else begin
				if (wr_q)
					mem[byte_address] <= lanes;
				if (!wr_q) begin
					ptr_q <= 6'h00;
					hunt_q <= 1'b1;
				end else if (hunt_q && byte_address < 21'h80000) begin
					if (lanes[0] == pat[ptr_q]) begin
						ptr_q <= ptr_q + 6'h01;
						if (ptr_q == 6'h3F) begin
							xfer_q <= 1'b1;
							hunt_q <= 1'b0;
						end
					end else
						hunt_q <= 1'b0;
				end
			end
		end
	end
endmodule

`default_nettype wire

// *** bench/tb_sram_hidden_rtc_access.sv ***
// testbench: register accesses drive memory and clock commands
// assumes shra_ctrl faces the behavioural device model
`timescale 1ns/10ps
`default_nettype none

module tb_sram_hidden_rtc_access;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, d;
	logic [1:0] r;
	logic chip_select_n, write_strobe_n, output_drive_n, serial_lane_oe_n;
	logic [20:0] byte_address;
	logic [7:0] serial_lane_out, serial_lane_in, dev_drv;
	int errors = 0, tests_run = 0;

	always #2.5 aclk = ~aclk;
	// host wins the lanes whenever it enables them
	assign serial_lane_in = !serial_lane_oe_n ? serial_lane_out : dev_drv;

	shra_ctrl shra_ctrl_i (.*);
	shra_dev_model shra_dev_model_i (.aclk(aclk), .chip_select_n(chip_select_n),
		.write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
		.byte_address(byte_address), .lanes(serial_lane_in), .dev_drv(dev_drv));

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ready is raised only once valid is seen, so the response must stand a cycle
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && !bready)
				bready <= 1'b1;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && !rready)
				rready <= 1'b1;
		end while (!(rvalid && rready));
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// start a command, poll for done, then clear done
	task automatic run_cmd(input logic [31:0] c);
		int n;
		logic [31:0] s;
		logic [1:0] rs;
		n = 0;
		s = 32'h0;
		axw(shra_pkg::REG_CTRL, c);
		while (s[1] !== 1'b1 && n < 3000) begin
			axr(shra_pkg::REG_STATUS, s, rs);
			n++;
		end
		chk(s & 32'h3, 32'h2);
		axw(shra_pkg::REG_STATUS, 32'h2);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// every register reads zero after reset, unmapped offset refused
		for (int i = 0; i < 8; i++) begin
			axr(8'(i * 4), d, r);
			chk(d, 32'h0);
		end
		axr(8'h20, d, r);
		chk({30'h0, r}, {30'h0, shra_pkg::RESP_SLVERR});
		axw(8'h20, 32'h0);
		chk({30'h0, r}, {30'h0, shra_pkg::RESP_SLVERR});
		// memory write and read back
		axw(shra_pkg::REG_SCRATCH, 32'h7FFFF);
		chk({30'h0, r}, {30'h0, shra_pkg::RESP_OKAY});
		axw(shra_pkg::REG_ADDR, 32'h12345);
		axw(shra_pkg::REG_WDATA, 32'hA5);
		run_cmd(32'h0);
		chk({24'h0, shra_dev_model_i.mem[21'h12345]}, 32'hA5);
		axw(shra_pkg::REG_WDATA, 32'h00);
		run_cmd(32'h1);
		axr(shra_pkg::REG_RDATA, d, r);
		chk(d, 32'hA5);
		// clock write: last image bit is 1, scratch must keep the unlock byte
		axw(shra_pkg::REG_TIME_LO, 32'h8765_4321);
		axw(shra_pkg::REG_TIME_HI, 32'h8BAD_F00D);
		run_cmd(32'h3);
		chk(shra_dev_model_i.time_q[31:0], 32'h8765_4321);
		chk(shra_dev_model_i.time_q[63:32], 32'h8BAD_F00D);
		chk({24'h0, shra_dev_model_i.mem[21'h7FFFF]}, 32'h0);
		// clock read after a fresh unlock
		axw(shra_pkg::REG_TIME_LO, 32'h0);
		axw(shra_pkg::REG_TIME_HI, 32'h0);
		run_cmd(32'h2);
		axr(shra_pkg::REG_TIME_LO, d, r);
		chk(d, 32'h8765_4321);
		axr(shra_pkg::REG_TIME_HI, d, r);
		chk(d, 32'h8BAD_F00D);
		// plain memory again once the transfer is over
		run_cmd(32'h1);
		axr(shra_pkg::REG_RDATA, d, r);
		chk(d, 32'hA5);
		tally_and_finish();
	end
endmodule

`default_nettype wire
